// ===== logic/cbd_top.sv
// Purpose: Processor bus timing, strobe synthesis, chip select decode and interrupt gating.
// Assumes: clk_sys at 50 MHz is much faster than the processor clock, which is sampled.
// Notes: Address, refresh and memory config are decoded directly; control pins pass the synchroniser, but the system latch strobe gates the raw pins.
// Notes on behaviour
// - Bus cycle runs T1, T2, T3, wait, T4.
// - Four timing pulses are flip-flops on processor clock.
// - First pulse sets at T1 rise, clears next rise.
// - Second pulse sets T1 fall, clears on ready with fourth.
// - Third pulse sets T2 rise, clears after second drops.
// - Fourth pulse sets T2 fall, clears after third drops.
// - First pulse one clock; others stretch with waits.
// - Buffer enable stays off for interrupt controller select.
// - System latch strobe blocked during hold acknowledge.
// - Strobes need no hold, second pulse, status.
// - I/O blocks decoded from address bits 15..7.
// - Block zero selects controller, timer, peripheral interface.
// - Block one selects enable port and sound.
// - Joystick, printer, floppy selects from blocks 4,6,7.
// - High graphics select for non-refresh memory accesses.
// - ROM selects only on non-refresh memory reads.
// - Memory select combines video, graphics, both ROMs.
// - Video select for low reads with no memory config, or graphics.
// - Eight maskable requests merged with software mask, priority.
// - Request lines fixed: timer through printer, 2-4 bus.
// - Bus NMI passes only while enable bit set.
// - Reset clears the NMI enable bit.
// - Each I/O cycle raises one-wait pulse.
// - Ready takes rising then falling processor edge.
`timescale 1ns/100ps
`include "cbd_defs.svh"
module cbd_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Processor side
  input wire logic processorClock,
  input wire logic cpuLatchStrobe,
  input wire logic holdAcknowledge,
  input wire logic memOrIoStatus,
  input wire logic transferDirectionStatus,
  input wire logic cycleStatusZero,
  input wire logic [19:0] busAddr,
  input wire logic [7:0] busDataIn,
  input wire logic refreshCycleN,
  input wire logic memConfigBitA,
  input wire logic memConfigBitB,
  input wire logic memConfigBitC,
  // Ready and interrupts from the system bus
  input wire logic sharedReady,
  input wire logic busNmi,
  input wire logic [7:0] irqLines,
  input wire logic [7:0] irqMask,
  input wire logic [2:0] irqTopPriority,
  // Timing and strobes
  output logic systemLatchStrobe,
  output logic dataBufferEnableN,
  output logic ioReadStrobeN,
  output logic ioWriteStrobeN,
  output logic memReadStrobeN,
  output logic memWriteStrobeN,
  output logic ioWaitPulse,
  output logic syncedReady,
  output logic [3:0] timingPulses,
  // I/O selects
  output logic ioBlockZeroSelN,
  output logic ioBlockOneSelN,
  output logic ioBlockFourSelN,
  output logic ioBlockSixSelN,
  output logic ioBlockSevenSelN,
  output logic irqCtrlSelectN,
  output logic intervalTimerSelectN,
  output logic periphIfaceSelectN,
  output logic nmiPortSelectN,
  output logic soundGenSelectN,
  output logic joystickSelectN,
  output logic printerSelectN,
  output logic floppySelectN,
  output logic ioTransceiverEnableN,
  // Memory selects
  output logic highGraphicsSelectN,
  output logic romZeroSelectN,
  output logic romOneSelectN,
  output logic videoSystemMemSelectN,
  output logic memorySelectN,
  // Interrupts to the processor
  output logic cpuIrq,
  output logic [2:0] irqHighest,
  output logic cpuNmi,
  output logic nmiEnable
);

  // ****************************************
  // Input synchronisation
  // ****************************************
  localparam int SYNC_W = 16;
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic pclk;
  logic latchS;
  logic holdS;
  logic readyS;
  logic nmiS;
  logic [7:0] irqS;
  cbd_pkg::cbd_cycle_t cycleKind;

  // Status bits sit so that the cycle kind reads {memory-or-I/O, direction, status zero}.
  assign syncIn = {irqLines, busNmi, sharedReady, memOrIoStatus, transferDirectionStatus,
                   cycleStatusZero, holdAcknowledge, cpuLatchStrobe, processorClock};

  cbd_sync3 #(
    .WIDTH(SYNC_W),
    .INIT(16'h0000)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(syncIn),
    .dout(syncOut)
  );

  assign pclk = syncOut[0];
  assign latchS = syncOut[1];
  assign holdS = syncOut[2];
  assign cycleKind = cbd_pkg::cbd_cycle_t'(syncOut[5:3]);
  assign readyS = syncOut[6];
  assign nmiS = syncOut[7];
  assign irqS = syncOut[15:8];

  // ****************************************
  // Processor clock edges
  // ****************************************
  logic pclkPrev;
  logic pclkRise;
  logic pclkFall;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pclkPrev <= 1'b0;
    end else begin
      pclkPrev <= pclk;
    end
  end

  assign pclkRise = pclk & ~pclkPrev;
  assign pclkFall = ~pclk & pclkPrev;

  // ****************************************
  // Timing pulses
  // ****************************************
  // Each pulse moves only on its own processor clock edge, so every half clock of
  // T1 and T2 is a distinct combination of the four.
  logic pulseA;
  logic pulseB;
  logic pulseC;
  logic pulseD;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulseA <= 1'b0;
    end else if (pclkRise) begin
      pulseA <= latchS;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulseB <= 1'b0;
    end else if (pclkFall) begin
      if (pulseA) begin
        pulseB <= 1'b1;
      end else if (syncedReady && pulseD) begin
        pulseB <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulseC <= 1'b0;
    end else if (pclkRise) begin
      if (pulseB) begin
        pulseC <= 1'b1;
      end else begin
        pulseC <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulseD <= 1'b0;
    end else if (pclkFall) begin
      pulseD <= pulseC;
    end
  end

  assign timingPulses = {pulseD, pulseC, pulseB, pulseA};

  // ****************************************
  // Strobe synthesis
  // ****************************************
  logic ioRd;
  logic ioWr;
  logic memRd;
  logic memWr;
  logic granted;

  assign granted = ~holdS;
  // Code fetches are memory reads too, so the memory read ignores status zero.
  assign ioRd = granted & pulseB & (cycleKind == cbd_pkg::CBD_CYC_IO_RD);
  assign ioWr = granted & pulseB & (cycleKind == cbd_pkg::CBD_CYC_IO_WR);
  assign memRd = granted & pulseB & ((cycleKind == cbd_pkg::CBD_CYC_MEM_RD) ||
                                     (cycleKind == cbd_pkg::CBD_CYC_CODE));
  assign memWr = granted & pulseB & (cycleKind == cbd_pkg::CBD_CYC_MEM_WR);

  assign ioReadStrobeN = ~ioRd;
  assign ioWriteStrobeN = ~ioWr;
  assign memReadStrobeN = ~memRd;
  assign memWriteStrobeN = ~memWr;
  assign systemLatchStrobe = ~holdAcknowledge & cpuLatchStrobe;

  // Read data is driven late in the cycle, write data as soon as the strobe opens.
  assign dataBufferEnableN = ~(granted & irqCtrlSelectN &
                               (((ioRd | memRd) & pulseC) | ioWr | memWr));

  // ****************************************
  // Ready synchroniser
  // ****************************************
  logic readyStage;

  assign ioWaitPulse = granted & pulseA & ((cycleKind == cbd_pkg::CBD_CYC_IO_RD) ||
                                           (cycleKind == cbd_pkg::CBD_CYC_IO_WR));

  // Sampling at the rise that ends T1 while the wait pulse is high costs exactly one wait.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readyStage <= 1'b0;
    end else if (pclkRise) begin
      readyStage <= readyS & ~ioWaitPulse;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncedReady <= 1'b0;
    end else if (pclkFall) begin
      syncedReady <= readyStage;
    end
  end

  // ****************************************
  // I/O decode
  // ****************************************
  logic [8:0] ioBlk;
  logic [3:0] ioSub;
  logic blk0;
  logic blk1;
  logic blk7;

  assign ioBlk = busAddr[`CBD_IO_BLK_MSB:`CBD_IO_BLK_LSB];
  assign ioSub = busAddr[`CBD_IO_SUB_MSB:`CBD_IO_SUB_LSB];
  assign blk0 = (ioBlk == `CBD_BLK_ZERO);
  assign blk1 = (ioBlk == `CBD_BLK_ONE);
  assign blk7 = (ioBlk == `CBD_BLK_SEVEN);

  assign ioBlockZeroSelN = ~blk0;
  assign ioBlockOneSelN = ~blk1;
  assign ioBlockFourSelN = ~(ioBlk == `CBD_BLK_FOUR);
  assign ioBlockSixSelN = ~(ioBlk == `CBD_BLK_SIX);
  assign ioBlockSevenSelN = ~blk7;

  assign irqCtrlSelectN = ~(blk0 && ioSub == `CBD_SUB_INTC);
  assign intervalTimerSelectN = ~(blk0 && ioSub == `CBD_SUB_TIMER);
  assign periphIfaceSelectN = ~(blk0 && ioSub == `CBD_SUB_PPI);
  assign nmiPortSelectN = ~(blk1 && ioSub == `CBD_SUB_NMI);
  assign soundGenSelectN = ~(blk1 && ioSub == `CBD_SUB_SOUND);
  assign joystickSelectN = ~(!ioBlockFourSelN && ioSub == `CBD_SUB_JOY);
  assign printerSelectN = ~(!ioBlockSixSelN && ioSub == `CBD_SUB_PRINT);
  assign floppySelectN = ~(blk7 && ioSub == `CBD_SUB_FLOPPY);

  // The interrupt controller sits on the local bus and never opens the I/O transceiver.
  assign ioTransceiverEnableN = intervalTimerSelectN & periphIfaceSelectN & nmiPortSelectN &
                                soundGenSelectN & printerSelectN & floppySelectN &
                                ~(blk7 && busAddr[`CBD_FLOPPY_GRP_MSB:`CBD_FLOPPY_GRP_LSB] ==
                                  `CBD_FLOPPY_GRP);

  // ****************************************
  // Memory decode
  // ****************************************
  logic hgSel;
  logic rom0Sel;
  logic rom1Sel;
  logic vsSel;
  logic [2:0] memCfg;

  assign memCfg = {memConfigBitC, memConfigBitB, memConfigBitA};
  assign hgSel = refreshCycleN & (memRd | memWr) &
                 (busAddr[`CBD_MEM_TOP_MSB:`CBD_MEM_TOP_LSB] == `CBD_HG_PATTERN);
  assign rom0Sel = refreshCycleN & memRd &
                   (busAddr[`CBD_ROM_MSB:`CBD_ROM_LSB] == `CBD_ROM0_PATTERN);
  assign rom1Sel = refreshCycleN & memRd &
                   (busAddr[`CBD_ROM_MSB:`CBD_ROM_LSB] == `CBD_ROM1_PATTERN);
  assign vsSel = (refreshCycleN & memRd & (memCfg == `CBD_MC_NONE) &
                  (busAddr[`CBD_VS_MSB:`CBD_VS_LSB] == `CBD_VS_PATTERN)) | hgSel;

  assign highGraphicsSelectN = ~hgSel;
  assign romZeroSelectN = ~rom0Sel;
  assign romOneSelectN = ~rom1Sel;
  assign videoSystemMemSelectN = ~vsSel;
  assign memorySelectN = ~(vsSel | hgSel | rom0Sel | rom1Sel);

  // ****************************************
  // Maskable interrupt merge
  // ****************************************
  // Line n is request n: timer, keyboard, three bus lines, vertical sync, floppy, printer.
  logic [7:0] irqPending;
  logic irqAny;
  logic [2:0] irqPick;

  assign irqPending = irqS & ~irqMask;
  assign irqAny = |irqPending;

  // Search starts at the software-chosen top line and rotates upward through the line numbers, wrapping after 7.
  always_comb begin
    logic [2:0] idx;
    irqPick = irqTopPriority;
    idx = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      idx = irqTopPriority + 3'(k);
      if (irqPending[idx]) begin
        irqPick = idx;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpuIrq <= 1'b0;
      irqHighest <= 3'h0;
    end else begin
      cpuIrq <= irqAny;
      irqHighest <= irqPick;
    end
  end

  // ****************************************
  // NMI enable port
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      nmiEnable <= `CBD_NMI_EN_RESET;
    end else if (ioWr && !nmiPortSelectN) begin
      nmiEnable <= busDataIn[`CBD_NMI_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpuNmi <= 1'b0;
    end else begin
      cpuNmi <= nmiS & nmiEnable;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cbCk @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [1:0] risesInA;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      risesInA <= 2'h0;
    end else if (!pulseA) begin
      risesInA <= 2'h0;
    end else if (pclkRise && risesInA != 2'h3) begin
      risesInA <= risesInA + 2'h1;
    end
  end

  property p_aOneClock;
    risesInA <= 2'h1;
  endproperty
  a_aOneClock: assert property (p_aOneClock) else $error("first pulse outlived one clock");

  property p_bFromA;
    pclkFall && pulseA |=> pulseB;
  endproperty
  a_bFromA: assert property (p_bFromA) else $error("second pulse missed first");

  property p_cFromB;
    $rose(pulseC) |-> $past(pulseB) && $past(pclkRise);
  endproperty
  a_cFromB: assert property (p_cFromB) else $error("third pulse rose wrongly");

  property p_dFromC;
    $rose(pulseD) |-> pulseC && $past(pclkFall);
  endproperty
  a_dFromC: assert property (p_dFromC) else $error("fourth pulse rose wrongly");

  property p_denIntc;
    (busAddr[`CBD_IO_BLK_MSB:`CBD_IO_BLK_LSB] == `CBD_BLK_ZERO) &&
    (busAddr[`CBD_IO_SUB_MSB:`CBD_IO_SUB_LSB] == `CBD_SUB_INTC) |-> dataBufferEnableN;
  endproperty
  a_denIntc: assert property (p_denIntc) else $error("buffer open for controller");

  property p_holdQuiet;
    holdAcknowledge && holdS |-> !systemLatchStrobe && ioReadStrobeN && ioWriteStrobeN &&
                                memReadStrobeN && memWriteStrobeN;
  endproperty
  a_holdQuiet: assert property (p_holdQuiet) else $error("strobe during hold");

  property p_romRead;
    !memWriteStrobeN |-> romZeroSelectN && romOneSelectN;
  endproperty
  a_romRead: assert property (p_romRead) else $error("ROM select on write");

  property p_nmiGate;
    cpuNmi |-> $past(nmiEnable) && $past(nmiS);
  endproperty
  a_nmiGate: assert property (p_nmiGate) else $error("NMI passed while disabled");

  property p_readyTwoEdges;
    $rose(syncedReady) |-> $past(pclkFall) && readyStage;
  endproperty
  a_readyTwoEdges: assert property (p_readyTwoEdges) else $error("ready not on fall");

  property p_memory_select;
    !memorySelectN |-> !videoSystemMemSelectN || !romZeroSelectN || !romOneSelectN;
  endproperty
  a_memory_select: assert property (p_memory_select) else $error("memory select without source");

endmodule

// ===== logic/cbd_defs.svh
// Purpose: Named addresses, field positions and reset values for the bus control block.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef CBD_DEFS_SVH
`define CBD_DEFS_SVH

// ****************************************
// I/O decode fields
// ****************************************
`define CBD_IO_BLK_MSB 15
`define CBD_IO_BLK_LSB 7
`define CBD_IO_SUB_MSB 6
`define CBD_IO_SUB_LSB 3
`define CBD_BLK_ZERO 9'h000
`define CBD_BLK_ONE 9'h001
`define CBD_BLK_FOUR 9'h004
`define CBD_BLK_SIX 9'h006
`define CBD_BLK_SEVEN 9'h007
`define CBD_SUB_INTC 4'h4
`define CBD_SUB_TIMER 4'h8
`define CBD_SUB_PPI 4'hc
`define CBD_SUB_NMI 4'h4
`define CBD_SUB_SOUND 4'h8
`define CBD_SUB_JOY 4'h0
`define CBD_SUB_PRINT 4'hf
`define CBD_SUB_FLOPPY 4'he
`define CBD_FLOPPY_GRP_MSB 6
`define CBD_FLOPPY_GRP_LSB 4
`define CBD_FLOPPY_GRP 3'h7

// ****************************************
// Memory decode fields
// ****************************************
`define CBD_MEM_TOP_MSB 19
`define CBD_MEM_TOP_LSB 15
`define CBD_HG_PATTERN 5'h13
`define CBD_VS_MSB 19
`define CBD_VS_LSB 17
`define CBD_VS_PATTERN 3'h0
`define CBD_MC_NONE 3'h0
`define CBD_ROM_MSB 19
`define CBD_ROM_LSB 13
`define CBD_ROM0_PATTERN 7'h6f
`define CBD_ROM1_PATTERN 7'h7e

// ****************************************
// Enable port
// ****************************************
`define CBD_NMI_PORT_ADDR 16'h00a0
`define CBD_NMI_EN_BIT 7
`define CBD_NMI_EN_RESET 1'b0

`endif

// ===== logic/cbd_pkg.sv
// Purpose: Types shared by the bus control block.
// Assumes: Status encoding is {memory-or-I/O, transmit-or-receive, status zero}.
// Notes: Values of the cycle kind are the raw status patterns.
package cbd_pkg;

  typedef enum logic [2:0] {
    CBD_CYC_CODE = 3'h0,
    CBD_CYC_MEM_RD = 3'h1,
    CBD_CYC_MEM_WR = 3'h2,
    CBD_CYC_PASSIVE = 3'h3,
    CBD_CYC_INTA = 3'h4,
    CBD_CYC_IO_RD = 3'h5,
    CBD_CYC_IO_WR = 3'h6,
    CBD_CYC_HALT = 3'h7
  } cbd_cycle_t;

endpackage

// ===== logic/cbd_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes: The output follows once the second and third stages agree.
`timescale 1ns/100ps
module cbd_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only when the two settled stages agree, so one glitch is never taken.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dout <= INIT;
    end else begin
      dout <= (~(stage2 ^ stage3) & stage2) | ((stage2 ^ stage3) & dout);
    end
  end

endmodule

// ===== tb/cbd_cpu_model.sv
// Purpose: Processor-side partner that runs local bus cycles on a slow processor clock.
// Assumes: Changes its pins on the falling edge of clk_sys; PH clk_sys cycles per half period.
// Notes: Idle status is passive and the released data bus shows the inverse of the last byte.
`timescale 1ns/100ps
module cbd_cpu_model #(
  parameter int PH = 10
) (
  // Clock
  input wire logic clk_sys,
  // Local bus
  output logic processorClock,
  output logic cpuLatchStrobe,
  output logic [2:0] status,
  output logic [19:0] busAddr,
  output logic [7:0] busDataIn,
  output logic sharedReady,
  // Sample points for the bench
  output logic markT1,
  output logic markT2
);
  initial begin
    processorClock = 1'b0;
    cpuLatchStrobe = 1'b0;
    status = 3'h3;
    busAddr = 20'h00000;
    busDataIn = 8'h00;
    sharedReady = 1'b1;
    markT1 = 1'b0;
    markT2 = 1'b0;
  end

  task automatic place(input logic [19:0] addr);
    busAddr = addr;
  endtask

  task automatic half(input logic lvl);
    @(negedge clk_sys);
    processorClock = lvl;
    markT1 = 1'b0;
    markT2 = 1'b0;
    repeat (PH - 1) @(negedge clk_sys);
  endtask

  // Seven clocks cover T1 to T4 plus the I/O wait and one ready wait.
  task automatic bus_cycle(input logic [2:0] kind, input logic [19:0] addr,
                           input logic [7:0] data, input logic slow);
    @(negedge clk_sys);
    status = kind;
    busAddr = addr;
    busDataIn = data;
    cpuLatchStrobe = 1'b1;
    sharedReady = ~slow;
    for (int i = 0; i < 7; i++) begin
      half(1'b1);
      markT1 = (i == 0);
      markT2 = (i == 1);
      half(1'b0);
      if (i == 0) begin
        cpuLatchStrobe = 1'b0;
      end
      if (i == 1) begin
        sharedReady = 1'b1;
      end
    end
    status = 3'h3;
    busDataIn = ~data;
  endtask
endmodule

// ===== tb/cpu_bus_control_decode_tb.sv
// Purpose: Self-checking bench for the bus control and decode block.
// Assumes: The partner model owns the processor clock, status, address and ready pins.
// Notes: Pulse widths are counted in clk_sys cycles, PH of them per processor half clock.
`timescale 1ns/100ps
module cpu_bus_control_decode_tb;
  localparam int PH = 10;
  logic clk_sys, rst, hold, refreshN, busNmi, cntClr;
  logic [2:0] mc, irqTop, stat, irqHighest;
  logic [7:0] irqLines, irqMask, dat;
  logic pclk, latch, ready, markT1, markT2, sysLatch, denN, io_wait_pulse, syncedReady;
  logic cpuIrq, cpuNmi, nmiEnable, snWait, snAle, snDen;
  logic [19:0] addr;
  logic [3:0] timingPulses, snStrb;
  wire [3:0] strb;
  wire [13:0] io_transceiver_enable;
  wire [4:0] memory_select;
  logic [4:0] snMem;
  logic [19:0] cnt [4];
  int nFail, checksDone;

  cbd_cpu_model #(.PH(PH)) cpu (.clk_sys(clk_sys), .processorClock(pclk),
    .cpuLatchStrobe(latch), .status(stat), .busAddr(addr), .busDataIn(dat),
    .sharedReady(ready), .markT1(markT1), .markT2(markT2));

  cbd_top DUT (.clk_sys(clk_sys), .rst(rst), .processorClock(pclk), .cpuLatchStrobe(latch),
    .holdAcknowledge(hold), .memOrIoStatus(stat[2]), .transferDirectionStatus(stat[1]),
    .cycleStatusZero(stat[0]), .busAddr(addr), .busDataIn(dat), .refreshCycleN(refreshN),
    .memConfigBitA(mc[0]), .memConfigBitB(mc[1]), .memConfigBitC(mc[2]),
    .sharedReady(ready), .busNmi(busNmi), .irqLines(irqLines), .irqMask(irqMask),
    .irqTopPriority(irqTop), .systemLatchStrobe(sysLatch), .dataBufferEnableN(denN),
    .ioReadStrobeN(strb[3]), .ioWriteStrobeN(strb[2]), .memReadStrobeN(strb[1]),
    .memWriteStrobeN(strb[0]), .ioWaitPulse(io_wait_pulse), .syncedReady(syncedReady),
    .timingPulses(timingPulses), .ioBlockZeroSelN(io_transceiver_enable[13]), .ioBlockOneSelN(io_transceiver_enable[12]),
    .ioBlockFourSelN(io_transceiver_enable[11]), .ioBlockSixSelN(io_transceiver_enable[10]), .ioBlockSevenSelN(io_transceiver_enable[9]),
    .irqCtrlSelectN(io_transceiver_enable[8]), .intervalTimerSelectN(io_transceiver_enable[7]),
    .periphIfaceSelectN(io_transceiver_enable[6]), .nmiPortSelectN(io_transceiver_enable[5]), .soundGenSelectN(io_transceiver_enable[4]),
    .joystickSelectN(io_transceiver_enable[3]), .printerSelectN(io_transceiver_enable[2]), .floppySelectN(io_transceiver_enable[1]),
    .ioTransceiverEnableN(io_transceiver_enable[0]), .highGraphicsSelectN(memory_select[4]),
    .romZeroSelectN(memory_select[3]), .romOneSelectN(memory_select[2]),
    .videoSystemMemSelectN(memory_select[1]), .memorySelectN(memory_select[0]), .cpuIrq(cpuIrq),
    .irqHighest(irqHighest), .cpuNmi(cpuNmi), .nmiEnable(nmiEnable));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Sampling and checking
  // ****************************************
  always @(posedge clk_sys) begin
    if (markT1) begin
      snWait <= io_wait_pulse;
      snAle <= sysLatch;
    end
    if (markT2) begin
      snStrb <= strb;
      snMem <= memory_select;
      snDen <= denN;
    end
    for (int k = 0; k < 4; k++) begin
      cnt[k] <= cntClr ? 20'h00000 : cnt[k] + {19'h00000, timingPulses[k]};
    end
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic run(input logic [2:0] kind, input logic [19:0] a, input logic [7:0] d,
                     input logic slow);
    @(negedge clk_sys);
    cntClr = 1'b1;
    @(negedge clk_sys);
    cntClr = 1'b0;
    cpu.bus_cycle(kind, a, d, slow);
    repeat (8) @(negedge clk_sys);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_io_decode();
    logic [15:0] a [10] = '{16'h0020, 16'h0040, 16'h0060, 16'h00a0, 16'h00c0, 16'h0200,
                            16'h0378, 16'h03f0, 16'h03f8, 16'h0420};
    logic [13:0] m [10] = '{14'h2100, 14'h2081, 14'h2041, 14'h1021, 14'h1011, 14'h0808,
                            14'h0405, 14'h0203, 14'h0201, 14'h0000};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      cpu.place({4'h0, a[i]});
      @(posedge clk_sys);
      check({6'h00, io_transceiver_enable}, {6'h00, ~m[i]}, "io select");
    end
  endtask

  task automatic t_cycles();
    logic [2:0] k [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [3:0] s [5] = '{4'hd, 4'hd, 4'he, 4'h7, 4'hb};
    logic io;
    for (int i = 0; i < 5; i++) begin
      io = k[i][2];
      run(k[i], io ? 20'h00040 : 20'h01000, 8'h00, 1'b0);
      check(snStrb, s[i], "strobes");
      check(snWait, io, "io wait");
      check(snAle, 1'b1, "latch out");
      check(snDen, 1'b0, "buffer on");
      check(cnt[0], 2 * PH, "pulse A");
      check(cnt[1], io ? 6 * PH : 4 * PH, "pulse B");
      check(cnt[2], io ? 6 * PH : 4 * PH, "pulse C");
      check(cnt[3], io ? 6 * PH : 4 * PH, "pulse D");
    end
  endtask

  task automatic t_wait_hold();
    run(3'h1, 20'h01000, 8'h00, 1'b1);
    check(cnt[1], 6 * PH, "ready wait");
    check(cnt[0], 2 * PH, "pulse A fixed");
    hold = 1'b1;
    run(3'h1, 20'h01000, 8'h00, 1'b0);
    check(snAle, 1'b0, "latch in hold");
    run(3'h6, 20'h000a0, 8'h80, 1'b0);
    check(snStrb, 4'hf, "strobes in hold");
    check(nmiEnable, 1'b0, "no write in hold");
    hold = 1'b0;
    run(3'h5, 20'h00020, 8'h00, 1'b0);
    check(snDen, 1'b1, "buffer off for controller");
  endtask

  task automatic t_mem_decode();
    logic [19:0] a [8] = '{20'h98000, 20'h98000, 20'hde000, 20'hde000, 20'hfc000,
                           20'h01000, 20'h01000, 20'h98000};
    logic w [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [4:0] e [8] = '{5'h0c, 5'h0c, 5'h16, 5'h1f, 5'h1a, 5'h1c, 5'h1f, 5'h1f};
    for (int i = 0; i < 8; i++) begin
      mc = (i == 6) ? 3'h1 : 3'h0;
      refreshN = (i != 7);
      run(w[i] ? 3'h2 : 3'h1, a[i], 8'h00, 1'b0);
      check(snMem, e[i], "memory select");
    end
    mc = 3'h0;
    refreshN = 1'b1;
  endtask

  task automatic t_irq();
    logic [7:0] ln [5] = '{8'h24, 8'h24, 8'h24, 8'h24, 8'h81};
    logic [7:0] mk [5] = '{8'h00, 8'h00, 8'h04, 8'h24, 8'h00};
    logic [2:0] tp [5] = '{3'h3, 3'h6, 3'h6, 3'h3, 3'h1};
    logic [2:0] hi [5] = '{3'h5, 3'h2, 3'h5, 3'h0, 3'h7};
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys);
      irqLines = ln[i];
      irqMask = mk[i];
      irqTop = tp[i];
      repeat (10) @(negedge clk_sys);
      check(cpuIrq, i != 3, "irq request");
      if (i != 3) begin
        check(irqHighest, hi[i], "irq chosen");
      end
    end
  endtask

  task automatic t_nmi();
    run(3'h6, 20'h000a8, 8'h80, 1'b0);
    check(nmiEnable, 1'b0, "neighbour port");
    run(3'h6, 20'h000a0, 8'h80, 1'b0);
    check(cpuNmi, 1'b1, "nmi passes");
    busNmi = 1'b0;
    repeat (10) @(negedge clk_sys);
    check(cpuNmi, 1'b0, "nmi follows bus");
    busNmi = 1'b1;
    run(3'h6, 20'h000a0, 8'h7f, 1'b0);
    check(cpuNmi, 1'b0, "nmi blocked");
    run(3'h6, 20'h000a0, 8'h80, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    check(nmiEnable, 1'b0, "enable cleared");
    check(cpuNmi, 1'b0, "nmi after reset");
  endtask

  task automatic complete_run();
    if (nFail == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang anywhere counts as a failure rather than a silent stall.
  initial begin
    repeat (100000) @(posedge clk_sys);
    nFail++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    hold = 1'b0;
    refreshN = 1'b1;
    mc = 3'h0;
    busNmi = 1'b1;
    irqLines = 8'h00;
    irqMask = 8'h00;
    irqTop = 3'h0;
    cntClr = 1'b0;
    nFail = 0;
    checksDone = 0;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (8) @(negedge clk_sys);
    check(nmiEnable, 1'b0, "enable at start");
    check(timingPulses, 4'h0, "pulses idle");
    t_io_decode();
    t_cycles();
    t_wait_hold();
    t_mem_decode();
    t_irq();
    t_nmi();
    complete_run();
  end
endmodule
